/* src/tmr5_pkg.sv */
`default_nettype none
package tmr5_pkg;

    localparam int unsigned NCH          = 5;
    localparam int unsigned PRESCALE_DIV = 12;
    localparam int unsigned SYS_CLK_HZ   = 20_000_000;

    // -------------------------------------------------------------------
    // Register indices (byte address on the bus is four times the index)
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_TCTL  = 8'h88;
    localparam logic [7:0] IDX_TMODE = 8'h89;
    localparam logic [7:0] IDX_AUX   = 8'h8e;
    localparam logic [7:0] IDX_ICLK  = 8'h8f;
    localparam logic [7:0] IDX_WAKEL = 8'haa;
    localparam logic [7:0] IDX_WAKEH = 8'hab;
    localparam logic [7:0] IDX_T34M  = 8'hd1;
    localparam logic [7:0] CNT_LO_IDX [NCH] =
        '{8'h8a, 8'h8b, 8'hd7, 8'hd5, 8'hd3};
    localparam logic [7:0] CNT_HI_IDX [NCH] =
        '{8'h8c, 8'h8d, 8'hd6, 8'hd4, 8'hd2};

    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] ICLK_MASK = 8'h77;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [15:0] CNT_ONES = 16'hffff;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int TCTL_OVF1 = 7;
    localparam int TCTL_RUN1 = 6;
    localparam int TCTL_OVF0 = 5;
    localparam int TCTL_RUN0 = 4;
    localparam int TM_GATE1  = 7;
    localparam int TM_SRC1   = 6;
    localparam int TM_MODE1  = 4;
    localparam int TM_GATE0  = 3;
    localparam int TM_SRC0   = 2;
    localparam int TM_MODE0  = 0;
    localparam int AUX_DIV0  = 7;
    localparam int AUX_DIV1  = 6;
    localparam int AUX_RUN2  = 4;
    localparam int AUX_SRC2  = 3;
    localparam int AUX_DIV2  = 2;
    localparam int ICLK_CO0  = 0;
    localparam int ICLK_CO1  = 1;
    localparam int ICLK_CO2  = 2;
    localparam int T34_RUN4  = 7;
    localparam int T34_SRC4  = 6;
    localparam int T34_DIV4  = 5;
    localparam int T34_CO4   = 4;
    localparam int T34_RUN3  = 3;
    localparam int T34_SRC3  = 2;
    localparam int T34_DIV3  = 1;
    localparam int T34_CO3   = 0;

    typedef enum logic [1:0] {
        MODE_AUTO16, MODE_FREE16, MODE_AUTO8, MODE_SPECIAL
    } tmr5_mode_t;

    typedef struct packed {
        logic       run;
        logic       gate;
        logic       extSrc;
        logic       fast;
        tmr5_mode_t mode;
        logic       clkOutEn;
    } tmr5_cfg_t;

endpackage
`default_nettype wire

/* src/tmr5_timer_counter.sv */
`default_nettype none
module tmr5_timer_counter #(
    parameter int unsigned ADDR_W   = 10,
    parameter int unsigned PRESCALE = tmr5_pkg::PRESCALE_DIV
) (
    input  wire logic                     sys_clk,
    input  wire logic                     arst_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [tmr5_pkg::NCH-1:0] countPin,
    input  wire logic [1:0]               extIrqPin,
    input  wire logic [1:0]               irqEnable,
    input  wire logic [1:0]               irqAck,
    output logic      [1:0]               irqReq,
    output logic      [tmr5_pkg::NCH-1:0] overflowTick,
    output logic      [tmr5_pkg::NCH-1:0] clockOut
);
    import tmr5_pkg::*;

    function automatic logic [7:0] regIndex(input logic [ADDR_W-1:0] a);
        regIndex = 8'(a[ADDR_W-1:2]);
    endfunction

    logic [7:0]  tctl;
    logic [7:0]  next_tctl;
    logic [7:0]  tmode;
    logic [7:0]  aux;
    logic [7:0]  iclk;
    logic [7:0]  wakeLo;
    logic [7:0]  wakeHi;
    logic [7:0]  t34m;
    logic [15:0] cnt    [NCH];
    logic [15:0] reload [NCH];
    logic [3:0]  preCnt;
    logic        tick12;
    logic [NCH-1:0] pinPrev;
    logic [NCH-1:0] pinEdge;
    tmr5_cfg_t   cfg    [NCH];
    logic [NCH-1:0] active;
    logic [NCH-1:0] step;
    logic [NCH-1:0] ovf;
    logic [NCH-1:0] auto16;
    logic [NCH-1:0] eight;
    logic [NCH-1:0] wrLo;
    logic [NCH-1:0] wrHi;
    logic [NCH-1:0] cntDirect;
    logic [7:0]  rdMux;
    logic        mapped;
    logic        wrEn;
    logic [7:0]  wrIdx;

    // -------------------------------------------------------------------
    // APB slave
    // -------------------------------------------------------------------
    always_comb begin
        rdMux  = RST_BYTE;
        mapped = (paddr[1:0] == 2'b00);
        case (regIndex(paddr))
            IDX_TCTL:  rdMux = tctl;
            IDX_TMODE: rdMux = tmode;
            IDX_AUX:   rdMux = aux;
            IDX_ICLK:  rdMux = iclk & ICLK_MASK;
            IDX_WAKEL: rdMux = wakeLo;
            IDX_WAKEH: rdMux = wakeHi;
            IDX_T34M:  rdMux = t34m;
            default: begin
                mapped = 1'b0;
                for (int c = 0; c < NCH; c++) begin
                    if (regIndex(paddr) == CNT_LO_IDX[c]) begin
                        rdMux  = cnt[c][7:0];
                        mapped = (paddr[1:0] == 2'b00);
                    end
                    if (regIndex(paddr) == CNT_HI_IDX[c]) begin
                        rdMux  = cnt[c][15:8];
                        mapped = (paddr[1:0] == 2'b00);
                    end
                end
            end
        endcase
    end

    assign wrIdx = regIndex(paddr);
    assign wrEn  = psel && penable && pready && pwrite && mapped;

    // Read data is captured in the setup cycle so prdata is a flop
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable) begin
                prdata <= {24'h00_0000, mapped ? rdMux : RST_BYTE};
            end
        end
    end

    // -------------------------------------------------------------------
    // Control registers
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tmode  <= RST_BYTE;
            aux    <= RST_BYTE;
            iclk   <= RST_BYTE;
            wakeLo <= RST_BYTE;
            wakeHi <= RST_BYTE;
            t34m   <= RST_BYTE;
        end else if (wrEn) begin
            case (wrIdx)
                IDX_TMODE: tmode  <= pwdata[7:0];
                IDX_AUX:   aux    <= pwdata[7:0];
                IDX_ICLK:  iclk   <= pwdata[7:0] & ICLK_MASK;
                IDX_WAKEL: wakeLo <= pwdata[7:0];
                IDX_WAKEH: wakeHi <= pwdata[7:0];
                IDX_T34M:  t34m   <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_tctl = tctl;
        if (wrEn && wrIdx == IDX_TCTL) begin
            next_tctl = pwdata[7:0];
        end
        if (irqAck[0]) begin
            next_tctl[TCTL_OVF0] = 1'b0;
        end
        if (irqAck[1]) begin
            next_tctl[TCTL_OVF1] = 1'b0;
        end
        if (ovf[0]) begin
            next_tctl[TCTL_OVF0] = 1'b1;
        end
        if (ovf[1]) begin
            next_tctl[TCTL_OVF1] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tctl <= RST_BYTE;
        end else begin
            tctl <= next_tctl;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqReq <= 2'b00;
        end else begin
            irqReq[0] <= tctl[TCTL_OVF0] &&
                         (irqEnable[0] || cfg[0].mode == MODE_SPECIAL);
            irqReq[1] <= tctl[TCTL_OVF1] && irqEnable[1];
        end
    end

    // -------------------------------------------------------------------
    // Channel configuration
    // -------------------------------------------------------------------
    // Source bits for 0 and 1
    // Source bits for 3 and 4
    always_comb begin
        cfg[0] = '{tctl[TCTL_RUN0], tmode[TM_GATE0], tmode[TM_SRC0],
                   aux[AUX_DIV0], tmr5_mode_t'(tmode[TM_MODE0 +: 2]),
                   iclk[ICLK_CO0]};
        cfg[1] = '{tctl[TCTL_RUN1], tmode[TM_GATE1], tmode[TM_SRC1],
                   aux[AUX_DIV1], tmr5_mode_t'(tmode[TM_MODE1 +: 2]),
                   iclk[ICLK_CO1]};
        cfg[2] = '{aux[AUX_RUN2], 1'b0, aux[AUX_SRC2], aux[AUX_DIV2],
                   MODE_AUTO16, iclk[ICLK_CO2]};
        cfg[3] = '{t34m[T34_RUN3], 1'b0, t34m[T34_SRC3], t34m[T34_DIV3],
                   MODE_AUTO16, t34m[T34_CO3]};
        cfg[4] = '{t34m[T34_RUN4], 1'b0, t34m[T34_SRC4], t34m[T34_DIV4],
                   MODE_AUTO16, t34m[T34_CO4]};
    end

    // -------------------------------------------------------------------
    // Shared prescaler and pin edges
    // -------------------------------------------------------------------
    assign tick12 = (preCnt == 4'(PRESCALE - 1));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            preCnt <= '0;
        end else if (tick12) begin
            preCnt <= '0;
        end else begin
            preCnt <= preCnt + 4'd1;
        end
    end

    // One step per rising pin edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinPrev <= '0;
        end else begin
            pinPrev <= countPin;
        end
    end
    assign pinEdge = countPin & ~pinPrev;

    // -------------------------------------------------------------------
    // Count qualification and overflow
    // -------------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            active[c] = cfg[c].run;
            if (c < 2 && cfg[c].gate) begin
                active[c] = cfg[c].run && extIrqPin[1'(c)];
            end
            if (c == 1 && cfg[c].mode == MODE_SPECIAL) begin
                active[c] = 1'b0;
            end
            step[c] = active[c] && (cfg[c].extSrc ? pinEdge[c] :
                                    (cfg[c].fast ? 1'b1 : tick12));
            auto16[c] = (cfg[c].mode == MODE_AUTO16) ||
                        (cfg[c].mode == MODE_SPECIAL);
            eight[c]  = (cfg[c].mode == MODE_AUTO8);
            ovf[c] = step[c] && (eight[c] ? (cnt[c][7:0] == BYTE_ONES)
                                          : (cnt[c] == CNT_ONES));
            wrLo[c] = wrEn && wrIdx == CNT_LO_IDX[c];
            wrHi[c] = wrEn && wrIdx == CNT_HI_IDX[c];
            // Running reload channels keep counting; writes go to reload
            cntDirect[c] = !cfg[c].run || !auto16[c];
        end
    end

    // -------------------------------------------------------------------
    // Counters and hidden reload registers
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < NCH; c++) begin
                cnt[c]    <= '0;
                reload[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (wrLo[c]) begin
                    reload[c][7:0] <= pwdata[7:0];
                end
                if (wrHi[c]) begin
                    reload[c][15:8] <= pwdata[7:0];
                end
                if ((wrLo[c] || wrHi[c]) && cntDirect[c]) begin
                    if (wrLo[c]) begin
                        cnt[c][7:0] <= pwdata[7:0];
                    end
                    if (wrHi[c]) begin
                        cnt[c][15:8] <= pwdata[7:0];
                    end
                end else if (step[c]) begin
                    // Low byte reloads from high byte
                    if (eight[c]) begin
                        cnt[c][7:0] <= ovf[c] ? cnt[c][15:8]
                                              : cnt[c][7:0] + 8'd1;
                    end else if (ovf[c] && auto16[c]) begin
                        cnt[c] <= reload[c];
                    end else begin
                        cnt[c] <= cnt[c] + 16'd1;
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Overflow ticks and clock outputs
    // -------------------------------------------------------------------
    // Overflow ticks exported
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            overflowTick <= '0;
            clockOut     <= '0;
        end else begin
            overflowTick <= ovf;
            for (int c = 0; c < NCH; c++) begin
                if (ovf[c] && cfg[c].clkOutEn) begin
                    clockOut[c] <= ~clockOut[c];
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence ovfReload0_s;
        ovf[0] && auto16[0] && !wrLo[0] && !wrHi[0];
    endsequence
    sequence ovfFree2Byte1_s;
        ovf[0] && cfg[0].mode == MODE_FREE16 && !wrLo[0] && !wrHi[0];
    endsequence

    prescale_period_a: assert property (
        tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
        else $error("prescaler period is not twelve");
    reload_load_a: assert property (
        ovfReload0_s |=> cnt[0] == $past(reload[0]))
        else $error("reload not loaded on overflow");
    free_wrap_a: assert property (
        ovfFree2Byte1_s |=> cnt[0] == 16'h0000)
        else $error("free mode did not wrap to zero");
    flag_set_a: assert property (
        ovf[0] |=> tctl[TCTL_OVF0]
        ##1 (irqReq[0] || !$past(irqEnable[0])))
        else $error("overflow flag or request missing");
    special_irq_a: assert property (
        tctl[TCTL_OVF0] && cfg[0].mode == MODE_SPECIAL |=> irqReq[0])
        else $error("mode 3 request was masked");
    ch1_halt_a: assert property (
        cfg[1].mode == MODE_SPECIAL && !wrLo[1] && !wrHi[1]
        |=> $stable(cnt[1]))
        else $error("channel 1 moved in mode 3");
    gate_hold_a: assert property (
        cfg[0].gate && !extIrqPin[0] && !wrLo[0] && !wrHi[0]
        |=> $stable(cnt[0]))
        else $error("gated channel counted");
    step_inc_a: assert property (
        step[2] && !ovf[2] && !wrLo[2] && !wrHi[2]
        |=> cnt[2] == $past(cnt[2]) + 16'd1)
        else $error("counter did not step by one");
    pin_count_a: assert property (
        !countPin[3] ##1 countPin[3] && cfg[3].run && cfg[3].extSrc
        |-> step[3])
        else $error("pin edge not counted");
    clk_toggle_a: assert property (
        ovf[4] && cfg[4].clkOutEn |=> clockOut[4] != $past(clockOut[4]))
        else $error("clock out did not toggle");
    byte_reload_a: assert property (
        ovf[1] && eight[1] && !wrLo[1] && !wrHi[1]
        |=> cnt[1][7:0] == cnt[1][15:8])
        else $error("8-bit reload failed");

endmodule
`default_nettype wire

/* tb/tmr5_pulse_src.sv */
`default_nettype none
// ----------------------------------------------------------------------
// External pulse source on the counter input pins
// ----------------------------------------------------------------------
module tmr5_pulse_src (
    input  wire logic       sys_clk,
    output logic      [4:0] countPin
);
    timeunit 1ns;
    timeprecision 1ns;

    initial countPin = 5'h00;

    // Two clocks high and two low, so a synchroniser never misses an edge
    task automatic pulse(input int ch, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            countPin[ch] <= 1'b1;
            repeat (2) @(posedge sys_clk);
            countPin[ch] <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
endmodule
`default_nettype wire

/* tb/test_tmr5_timer_counter.sv */
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    error_cnt++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_tmr5_timer_counter;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr5_pkg::*;

    // ------------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, lastErr;
    logic [4:0]  countPin, overflowTick, clockOut;
    logic [1:0]  extIrqPin = 2'b00, irqEnable = 2'b00, irqAck = 2'b00;
    logic [1:0]  irqReq;
    logic [7:0]  q;
    logic [15:0] v, w;
    int          error_cnt = 0, checks_done = 0, n, seed = 32'hff13_9b40;
    int          ovfCnt [5] = '{0, 0, 0, 0, 0};

    localparam logic [7:0] SRC_VAL [5] = '{8'h04, 8'h40, 8'h08, 8'h04, 8'h40};
    localparam logic [7:0] RUN_IDX [5] =
        '{IDX_TCTL, IDX_TCTL, IDX_AUX, IDX_T34M, IDX_T34M};
    localparam logic [7:0] SRC_IDX [5] =
        '{IDX_TMODE, IDX_TMODE, IDX_AUX, IDX_T34M, IDX_T34M};
    localparam logic [7:0] RUN_VAL [5] = '{8'h10, 8'h40, 8'h18, 8'h0c, 8'hc0};
    localparam logic [7:0] STP_VAL [5] = '{8'h00, 8'h00, 8'h08, 8'h04, 8'h40};
    localparam logic [7:0] RST_LIST [7] =
        '{IDX_TCTL, IDX_TMODE, IDX_AUX, IDX_ICLK, IDX_T34M, 8'h8a, 8'hd7};

    always #25 sys_clk = ~sys_clk;

    tmr5_timer_counter i_tmr5_timer_counter (
        .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .countPin(countPin), .extIrqPin(extIrqPin),
        .irqEnable(irqEnable), .irqAck(irqAck), .irqReq(irqReq),
        .overflowTick(overflowTick), .clockOut(clockOut)
    );
    tmr5_pulse_src i_tmr5_pulse_src (.sys_clk(sys_clk), .countPin(countPin));

    always @(posedge sys_clk)
        for (int c = 0; c < 5; c++)
            if (overflowTick[c] === 1'b1) ovfCnt[c]++;

    // ------------------------------------------------------------------
    // Expectation and bus helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] stepCnt(input logic [15:0] s, input int k,
                                            input logic [1:0] m,
                                            input logic [15:0] r);
        for (int i = 0; i < k; i++)
            if (m == 2'd2)
                s[7:0] = (s[7:0] == 8'hff) ? s[15:8] : s[7:0] + 8'h01;
            else if (m == 2'd1 || s != 16'hffff)
                s = s + 16'h0001;
            else
                s = r;
        return s;
    endfunction

    // Setup edge, then access phase until pready is seen at a rising
    // edge; data is taken at that edge and released right after it
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d, output logic [7:0] rq);
        int t;
        t = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rq = prdata[7:0];
        lastErr = pslverr;
        if (t >= 20) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        apb(1'b1, idx, d, x);
    endtask

    task automatic load(input int c, input logic [15:0] val);
        wr(CNT_LO_IDX[c], val[7:0]);
        wr(CNT_HI_IDX[c], val[15:8]);
    endtask

    task automatic getc(input int c, output logic [15:0] val);
        apb(1'b0, CNT_LO_IDX[c], 8'h00, val[7:0]);
        apb(1'b0, CNT_HI_IDX[c], 8'h00, val[15:8]);
    endtask

    task automatic countRun(input int c, input logic [7:0] src,
                            input logic [15:0] val, input int k);
        wr(SRC_IDX[c], src);
        load(c, val);
        wr(RUN_IDX[c], RUN_VAL[c]);
        i_tmr5_pulse_src.pulse(c, k);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        foreach (RST_LIST[i]) begin
            apb(1'b0, RST_LIST[i], 8'h00, q);
            `CHK("reset value", 8'h00, q)
        end
        apb(1'b1, 8'h00, 8'h5a, q);
        `CHK("unmapped error", 1'b1, lastErr)
        $display("test reset done");
        for (int c = 0; c < 5; c++) begin
            v = 16'($random(seed)) & 16'h7f7f;
            n = 1 + ({$random(seed)} % 20);
            countRun(c, SRC_VAL[c], v, n);
            wr(RUN_IDX[c], STP_VAL[c]);
            getc(c, w);
            `CHK("pin count", stepCnt(v, n, 2'd0, v), w)
        end
        $display("test counters done");
        countRun(0, 8'h0c, 16'h0000, 5);
        getc(0, w);
        `CHK("gate closed", 16'h0000, w)
        extIrqPin <= 2'b01;
        i_tmr5_pulse_src.pulse(0, 5);
        repeat (4) @(posedge sys_clk);
        getc(0, w);
        `CHK("gate open", 16'h0005, w)
        wr(IDX_TCTL, 8'h00);
        countRun(1, 8'h70, 16'h0010, 4);
        getc(1, w);
        `CHK("ch1 mode3 hold", 16'h0010, w)
        wr(IDX_TCTL, 8'h00);
        countRun(1, 8'h60, 16'hf0fe, 3);
        wr(IDX_TCTL, 8'h00);
        getc(1, w);
        `CHK("8-bit reload", stepCnt(16'hf0fe, 3, 2'd2, 0), w)
        countRun(0, 8'h05, 16'hffff, 1);
        wr(IDX_TCTL, 8'h00);
        getc(0, w);
        `CHK("free run wrap", 16'h0000, w)
        $display("test modes done");
        wr(IDX_TMODE, 8'h01);
        load(0, 16'h0000);
        wr(IDX_TCTL, 8'h10);
        repeat (240) @(posedge sys_clk);
        wr(IDX_TCTL, 8'h00);
        getc(0, w);
        `CHK("div 12 rate", 1'b1, w >= 16'd19 && w <= 16'd22)
        load(3, 16'h0000);
        wr(IDX_T34M, 8'h0a);
        repeat (40) @(posedge sys_clk);
        wr(IDX_T34M, 8'h00);
        getc(3, w);
        `CHK("div 1 rate", 1'b1, w >= 16'd40 && w <= 16'd44)
        $display("test timers done");
        irqEnable <= 2'b01;
        n = ovfCnt[0];
        countRun(0, 8'h04, 16'hfffe, 2);
        `CHK("irq request", 1'b1, irqReq[0])
        `CHK("ovf tick", n + 1, ovfCnt[0])
        apb(1'b0, IDX_TCTL, 8'h00, q);
        `CHK("flag set", 8'h30, q)
        irqAck <= 2'b01;
        @(posedge sys_clk);
        irqAck <= 2'b00;
        repeat (3) @(posedge sys_clk);
        `CHK("ack clears", 1'b0, irqReq[0])
        wr(IDX_TCTL, 8'h00);
        getc(0, w);
        `CHK("16-bit reload", 16'hfffe, w)
        irqEnable <= 2'b00;
        countRun(0, 8'h07, 16'hfffe, 2);
        `CHK("mode3 unmasked", 1'b1, irqReq[0])
        wr(IDX_TCTL, 8'h00);
        countRun(0, 8'h04, 16'hfffe, 2);
        `CHK("masked irq", 1'b0, irqReq[0])
        $display("test interrupts done");
        wr(IDX_TCTL, 8'h00);
        wr(IDX_ICLK, 8'h04);
        q[0] = clockOut[2];
        n = ovfCnt[2];
        countRun(2, 8'h08, 16'hffff, 1);
        `CHK("clock out toggle", ~q[0], clockOut[2])
        `CHK("baud tick", n + 1, ovfCnt[2])
        wr(IDX_AUX, 8'h08);
        getc(2, w);
        `CHK("stopped reload", 16'hffff, w)
        // Channel 2 timer on the undivided clock
        load(2, 16'h0000);
        wr(IDX_AUX, 8'h14);
        repeat (40) @(posedge sys_clk);
        wr(IDX_AUX, 8'h00);
        getc(2, w);
        `CHK("ch2 div 1", 1'b1, w >= 16'd40 && w <= 16'd44)
        $display("test clock out done");
        give_verdict();
    end
endmodule
`undef CHK
`default_nettype wire
